// File: hdl/core_clk_divider.sv
// Core clock enable divider with select codes for 1, 2, 4 and 8
`timescale 1ns/100ps
module core_clk_divider
	import otp_cfg_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic [2:0] div_sel_i,
	output logic tick_o
);
	logic [2:0] count_ff;
	logic [2:0] term;

	assign term = div_terminal(div_sel_i);

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || !run_i)
		begin
			count_ff <= 3'h0;
		end
		else if (count_ff >= term)
		begin
			count_ff <= 3'h0;
		end
		else
		begin
			count_ff <= count_ff + 3'h1;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || !run_i)
		begin
			tick_o <= 1'b0;
		end
		else
		begin
			tick_o <= (count_ff >= term);
		end
	end
endmodule

// File: hdl/otp_cfg_pkg.sv
// Shared constants, types and layout of the OTP configuration map
package otp_cfg_pkg;
	localparam int OTP_ADDR_W = 9;
	localparam int OTP_DATA_W = 8;
	// Byte addresses in OTP
	localparam logic [8:0] ADDR_CFG_A = 9'h000;
	localparam logic [8:0] ADDR_CLK_SENSE = 9'h003;
	localparam logic [8:0] ADDR_VALID = 9'h004;
	localparam logic [8:0] ADDR_CHAR_FMT0 = 9'h005;
	localparam logic [8:0] ADDR_CHAR_FMT6 = 9'h00b;
	localparam logic [8:0] ADDR_VEND_LO = 9'h00c;
	localparam logic [8:0] ADDR_VEND_HI = 9'h00d;
	localparam logic [8:0] ADDR_PROD_LO = 9'h00e;
	localparam logic [8:0] ADDR_PROD_HI = 9'h00f;
	localparam logic [8:0] ADDR_ATTR = 9'h010;
	localparam logic [8:0] ADDR_MAX_PWR = 9'h011;
	localparam logic [8:0] ADDR_STR_MFR = 9'h012;
	localparam logic [8:0] ADDR_STR_PROD = 9'h022;
	localparam logic [8:0] ADDR_STR_SER = 9'h032;
	localparam logic [8:0] ADDR_USER = 9'h042;
	localparam logic [8:0] ADDR_LOAD_LAST = ADDR_MAX_PWR;
	// Field positions
	localparam int POS_LP_POL = 1;
	localparam int POS_SENSE_EN = 3;
	localparam int POS_DIV_LSB = 0;
	localparam int POS_VALID_USB = 0;
	localparam int POS_VALID_STR = 1;
	localparam int POS_VALID_FMT = 2;
	localparam int POS_SELF_PWR = 6;
	localparam int POS_REMOTE_WAKE = 5;
	// Core clock divider codes
	localparam logic [2:0] core_div_one = 3'h0;
	localparam logic [2:0] core_div_two = 3'h1;
	localparam logic [2:0] core_div_four = 3'h2;
	localparam logic [2:0] core_div_eight = 3'h3;
	// String descriptor selectors
	localparam logic [1:0] STR_SEL_MFR = 2'h0;
	localparam logic [1:0] STR_SEL_PROD = 2'h1;
	localparam logic [1:0] STR_SEL_SER = 2'h2;
	// Built-in defaults
	localparam logic [31:0] DEF_BAUD = 32'h0001c200;
	localparam logic [7:0] DEF_STOP = 8'h00;
	localparam logic [7:0] DEF_PARITY = 8'h00;
	localparam logic [7:0] DEF_DATA_BITS = 8'h08;
	localparam logic [7:0] DEF_MAX_PWR = 8'h32;

	typedef struct packed {
		logic [31:0] baud;
		logic [7:0] stop_bits;
		logic [7:0] parity;
		logic [7:0] data_bits;
	} char_format_s;

	typedef enum logic [4:0] {
		ST_FETCH = 5'h01,
		ST_CAPTURE = 5'h02,
		ST_IDLE = 5'h04,
		ST_HOST_RD = 5'h08,
		ST_STR_RD = 5'h10
	} load_state_e;

	// Divide ratio minus one for a select code; reserved codes fall to the slowest
	function automatic logic [2:0] div_terminal(input logic [2:0] sel);
		case (sel)
			core_div_one: div_terminal = 3'h0;
			core_div_two: div_terminal = 3'h1;
			core_div_four: div_terminal = 3'h3;
			default: div_terminal = 3'h7;
		endcase
	endfunction
endpackage

// File: hdl/otp_store.sv
// One-time-programmable byte array with registered read data
`timescale 1ns/100ps
module otp_store
	import otp_cfg_pkg::*;
#(
	parameter int ADDR_W = OTP_ADDR_W,
	parameter int DATA_W = OTP_DATA_W
)
(
	input wire logic core_clk_i,
	input wire logic rd_en_i,
	input wire logic wr_en_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	output logic [DATA_W-1:0] rdata_o
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	if (ADDR_W < 7 || DATA_W != 8)
	begin : g_bad
		$error("otp_store: map needs at least 7 address bits and byte data");
	end

	// Blank fuses read as zero
	initial
	begin
		for (int i = 0; i < (1<<ADDR_W); i++)
		begin
			mem[i] = '0;
		end
	end

	// Programming can only set bits, never clear them
	always_ff @(posedge core_clk_i)
	begin
		if (wr_en_i)
		begin
			mem[addr_i] <= mem[addr_i] | wdata_i;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rd_en_i)
		begin
			rdata_o <= mem[addr_i];
		end
	end
endmodule

// File: hdl/otp_usb_config_override.sv
// Loads OTP configuration after reset and applies clock, pin and descriptor overrides
//
// How it works
// - Select divides core clock by 1,2,4,8
// - Config byte bit 1 sets low-power polarity
// - Sense byte bit 3 enables bus-voltage sensing
// - Valid bit 0 overrides descriptor fields
// - Valid bit 1 serves strings from OTP
// - Valid bit 2 takes power-up format from OTP
// - Format bytes follow line-coding payload layout
// - Vendor ID from low and high bytes
// - Product ID from low and high bytes
// - Valid bit 0 clear reports built-in IDs
// - OTP reached only through the USB side
`timescale 1ns/100ps
module otp_usb_config_override
	import otp_cfg_pkg::*;
#(
	parameter logic [15:0] BUILTIN_VENDOR_ID = 16'h1234,   // Arbitrary value
	parameter logic [15:0] BUILTIN_PRODUCT_ID = 16'h5678,  // Arbitrary value
	parameter logic BUILTIN_SELF_PWR = 1'b0,
	parameter logic BUILTIN_REMOTE_WAKE = 1'b1
)
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic otp_req_i,
	input wire logic otp_we_i,
	input wire logic [8:0] otp_addr_i,
	input wire logic [7:0] otp_wdata_i,
	output logic [7:0] otp_rdata_o,
	output logic otp_ack_o,
	input wire logic str_req_i,
	input wire logic [1:0] str_sel_i,
	input wire logic [3:0] str_idx_i,
	output logic [7:0] str_data_o,
	output logic str_ack_o,
	output logic strings_from_otp_o,
	input wire logic suspend_i,
	output logic low_power_o,
	output logic core_clk_en_o,
	output logic bus_voltage_sense_enable_o,
	output logic [15:0] vendor_id_o,
	output logic [15:0] product_id_o,
	output logic self_powered_o,
	output logic remote_wakeup_o,
	output logic [7:0] max_power_o,
	output char_format_s char_format_o,
	output logic config_done_o
);
	load_state_e state_ff;
	load_state_e nxt_state;
	logic [8:0] load_addr_ff;
	logic [8:0] mem_addr;
	logic mem_rd;
	logic mem_wr;
	logic [7:0] mem_rdata;
	logic done_ff;
	logic div_tick;
	logic [8:0] str_base;

	// Shadow copies, written only during the load walk
	logic [7:0] factory_config_byte_a_ff;
	logic [7:0] clock_and_sense_config_ff;
	logic [7:0] override_valid_flags_ff;
	logic [7:0] default_char_format_bytes_ff [0:6];
	logic [7:0] vendor_ident_low_ff;
	logic [7:0] vendor_ident_high_ff;
	logic [7:0] product_ident_low_ff;
	logic [7:0] product_ident_high_ff;
	logic [7:0] usb_power_attributes_ff;
	logic [7:0] usb_max_power_value_ff;

	always_comb
	begin
		case (str_sel_i)
			STR_SEL_MFR: str_base = ADDR_STR_MFR;
			STR_SEL_PROD: str_base = ADDR_STR_PROD;
			default: str_base = ADDR_STR_SER;
		endcase
	end

	// Loader owns the array until done; afterwards host accesses beat string reads
	// The ack cycle is refused, so a request still held there is not taken twice
	always_comb
	begin
		nxt_state = state_ff;
		mem_addr = load_addr_ff;
		mem_rd = 1'b0;
		mem_wr = 1'b0;
		case (state_ff)
			ST_FETCH:
			begin
				mem_rd = 1'b1;
				nxt_state = ST_CAPTURE;
			end
			ST_CAPTURE:
			begin
				nxt_state = (load_addr_ff == ADDR_LOAD_LAST) ? ST_IDLE : ST_FETCH;
			end
			ST_IDLE:
			begin
				if (otp_req_i && !otp_ack_o && !str_ack_o)
				begin
					mem_addr = otp_addr_i;
					mem_wr = otp_we_i;
					mem_rd = !otp_we_i;
					nxt_state = ST_HOST_RD;
				end
				else if (str_req_i && !otp_ack_o && !str_ack_o)
				begin
					mem_addr = str_base + {5'h00, str_idx_i};
					mem_rd = 1'b1;
					nxt_state = ST_STR_RD;
				end
			end
			ST_HOST_RD: nxt_state = ST_IDLE;
			ST_STR_RD: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			state_ff <= ST_FETCH;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			load_addr_ff <= ADDR_CFG_A;
		end
		else if (state_ff == ST_CAPTURE && load_addr_ff != ADDR_LOAD_LAST)
		begin
			load_addr_ff <= load_addr_ff + 9'h001;
		end
	end

	otp_store #(
		.ADDR_W(OTP_ADDR_W),
		.DATA_W(OTP_DATA_W)
	) u_store (
		.core_clk_i(core_clk_i),
		.rd_en_i(mem_rd),
		.wr_en_i(mem_wr),
		.addr_i(mem_addr),
		.wdata_i(otp_wdata_i),
		.rdata_o(mem_rdata)
	);

	// Capture each byte of interest as the walk passes its address
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			factory_config_byte_a_ff <= 8'h00;
			clock_and_sense_config_ff <= 8'h00;
			override_valid_flags_ff <= 8'h00;
			vendor_ident_low_ff <= 8'h00;
			vendor_ident_high_ff <= 8'h00;
			product_ident_low_ff <= 8'h00;
			product_ident_high_ff <= 8'h00;
			usb_power_attributes_ff <= 8'h00;
			usb_max_power_value_ff <= 8'h00;
			for (int i = 0; i < 7; i++)
			begin
				default_char_format_bytes_ff[i] <= 8'h00;
			end
		end
		else if (state_ff == ST_CAPTURE)
		begin
			case (load_addr_ff)
				ADDR_CFG_A: factory_config_byte_a_ff <= mem_rdata;
				ADDR_CLK_SENSE: clock_and_sense_config_ff <= mem_rdata;
				ADDR_VALID: override_valid_flags_ff <= mem_rdata;
				ADDR_VEND_LO: vendor_ident_low_ff <= mem_rdata;
				ADDR_VEND_HI: vendor_ident_high_ff <= mem_rdata;
				ADDR_PROD_LO: product_ident_low_ff <= mem_rdata;
				ADDR_PROD_HI: product_ident_high_ff <= mem_rdata;
				ADDR_ATTR: usb_power_attributes_ff <= mem_rdata;
				ADDR_MAX_PWR: usb_max_power_value_ff <= mem_rdata;
				default:
				begin
					if (load_addr_ff >= ADDR_CHAR_FMT0 && load_addr_ff <= ADDR_CHAR_FMT6)
					begin
						default_char_format_bytes_ff[3'(load_addr_ff - ADDR_CHAR_FMT0)] <= mem_rdata;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			done_ff <= 1'b0;
		end
		else if (state_ff == ST_CAPTURE && load_addr_ff == ADDR_LOAD_LAST)
		begin
			done_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			config_done_o <= 1'b0;
		end
		else
		begin
			config_done_o <= done_ff;
		end
	end

	// Divider held until the select is loaded, so the core never sees a wrong rate
	core_clk_divider u_div (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.run_i(done_ff),
		.div_sel_i(clock_and_sense_config_ff[POS_DIV_LSB +: 3]),
		.tick_o(div_tick)
	);

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			core_clk_en_o <= 1'b0;
		end
		else
		begin
			core_clk_en_o <= div_tick;
		end
	end

	// Before load the polarity reads as active low, so the pin idles high
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			low_power_o <= 1'b1;
		end
		else
		begin
			low_power_o <= factory_config_byte_a_ff[POS_LP_POL] ? suspend_i : !suspend_i;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			bus_voltage_sense_enable_o <= 1'b0;
			strings_from_otp_o <= 1'b0;
		end
		else
		begin
			bus_voltage_sense_enable_o <= done_ff & clock_and_sense_config_ff[POS_SENSE_EN];
			strings_from_otp_o <= done_ff & override_valid_flags_ff[POS_VALID_STR];
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			vendor_id_o <= BUILTIN_VENDOR_ID;
			product_id_o <= BUILTIN_PRODUCT_ID;
			self_powered_o <= BUILTIN_SELF_PWR;
			remote_wakeup_o <= BUILTIN_REMOTE_WAKE;
			max_power_o <= DEF_MAX_PWR;
		end
		else if (done_ff && override_valid_flags_ff[POS_VALID_USB])
		begin
			vendor_id_o <= {vendor_ident_high_ff, vendor_ident_low_ff};
			product_id_o <= {product_ident_high_ff, product_ident_low_ff};
			self_powered_o <= usb_power_attributes_ff[POS_SELF_PWR];
			remote_wakeup_o <= usb_power_attributes_ff[POS_REMOTE_WAKE];
			max_power_o <= usb_max_power_value_ff;
		end
		else
		begin
			vendor_id_o <= BUILTIN_VENDOR_ID;
			product_id_o <= BUILTIN_PRODUCT_ID;
			self_powered_o <= BUILTIN_SELF_PWR;
			remote_wakeup_o <= BUILTIN_REMOTE_WAKE;
			max_power_o <= DEF_MAX_PWR;
		end
	end

	// Little-endian rate, then stop bits, parity and data bits
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			char_format_o <= '{DEF_BAUD, DEF_STOP, DEF_PARITY, DEF_DATA_BITS};
		end
		else if (done_ff && override_valid_flags_ff[POS_VALID_FMT])
		begin
			char_format_o.baud <= {default_char_format_bytes_ff[3], default_char_format_bytes_ff[2],
				default_char_format_bytes_ff[1], default_char_format_bytes_ff[0]};
			char_format_o.stop_bits <= default_char_format_bytes_ff[4];
			char_format_o.parity <= default_char_format_bytes_ff[5];
			char_format_o.data_bits <= default_char_format_bytes_ff[6];
		end
		else
		begin
			char_format_o <= '{DEF_BAUD, DEF_STOP, DEF_PARITY, DEF_DATA_BITS};
		end
	end

	// Answers land two cycles after the access is taken; the extra cycle keeps outputs on flops
	// Read data is only meaningful with its ack; otherwise it reads zero
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			otp_ack_o <= 1'b0;
			str_ack_o <= 1'b0;
			otp_rdata_o <= 8'h00;
			str_data_o <= 8'h00;
		end
		else
		begin
			otp_ack_o <= (state_ff == ST_HOST_RD);
			str_ack_o <= (state_ff == ST_STR_RD);
			otp_rdata_o <= (state_ff == ST_HOST_RD) ? mem_rdata : 8'h00;
			str_data_o <= (state_ff == ST_STR_RD) ? mem_rdata : 8'h00;
		end
	end
endmodule

// File: tb/otp_cfg_asserts.sv
// Port checker for the OTP configuration loader
`timescale 1ns/100ps
module otp_cfg_asserts
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic otp_req_i,
	input wire logic suspend_i,
	input wire logic otp_ack_o,
	input wire logic [7:0] otp_rdata_o,
	input wire logic str_ack_o,
	input wire logic [7:0] str_data_o,
	input wire logic low_power_o,
	input wire logic core_clk_en_o,
	input wire logic [15:0] vendor_id_o,
	input wire logic [15:0] product_id_o,
	input wire logic config_done_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	a_ack_one_cycle: assert property (otp_ack_o |=> !otp_ack_o)
		else $error("host ack held too long");
	a_rdata_idle_zero: assert property (!otp_ack_o |-> otp_rdata_o == 8'h00)
		else $error("read data without ack");
	a_ack_needs_req: assert property (otp_ack_o |-> $past(otp_req_i))
		else $error("ack without request");
	a_no_ack_loading: assert property (!config_done_o |-> !otp_ack_o && !str_ack_o)
		else $error("ack during load");
	a_str_idle_zero: assert property (!str_ack_o |-> str_data_o == 8'h00)
		else $error("string data without ack");
	a_done_holds: assert property (config_done_o |=> config_done_o)
		else $error("load done dropped");
	a_ids_frozen: assert property (config_done_o && $past(config_done_o, 2)
		|-> $stable(vendor_id_o) && $stable(product_id_o))
		else $error("identifiers moved after load");
	a_en_period: assert property ($past(config_done_o) && core_clk_en_o
		|-> ##[1:8] core_clk_en_o)
		else $error("core enable gap above eight");
	a_lp_follows: assert property (config_done_o && $past(config_done_o) && $changed(suspend_i)
		|=> $changed(low_power_o))
		else $error("low-power output missed suspend change");
endmodule
bind otp_usb_config_override otp_cfg_asserts u_chk (.core_clk_i, .rst_n_i, .otp_req_i,
	.suspend_i, .otp_ack_o, .otp_rdata_o, .str_ack_o, .str_data_o, .low_power_o,
	.core_clk_en_o, .vendor_id_o, .product_id_o, .config_done_o);

// File: tb/otp_host_model.sv
// Host model that reads and programs OTP bytes over the USB path
`timescale 1ns/100ps
module otp_host_model
(
	input wire logic core_clk_i,
	input wire logic otp_ack_i,
	input wire logic [7:0] otp_rdata_i,
	output logic otp_req_o,
	output logic otp_we_o,
	output logic [8:0] otp_addr_o,
	output logic [7:0] otp_wdata_o
);
	initial
	begin
		otp_req_o = 1'b0;
		otp_we_o = 1'b0;
		otp_addr_o = 9'h1ff;
		otp_wdata_o = 8'hff;
	end
	// The bench table and the map constants pick addresses, so reserved codes and bits stay clear
	task automatic access(input logic we, input logic [8:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(negedge core_clk_i);
		otp_req_o = 1'b1;
		otp_we_o = we;
		otp_addr_o = a;
		otp_wdata_o = d;
		do
		begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
		while (otp_ack_i !== 1'b1 && n < 20);
		q = (otp_ack_i === 1'b1) ? otp_rdata_i : 8'hxx;
		@(negedge core_clk_i);
		otp_req_o = 1'b0;
		// Released lines show a changed value, not the last one
		otp_addr_o = ~a;
		otp_wdata_o = ~d;
	endtask
endmodule

// File: tb/otp_usb_config_override_tb_top.sv
// Self-checking bench for the OTP configuration loader
`timescale 1ns/100ps
module otp_usb_config_override_tb_top;
	import otp_cfg_pkg::*;
	localparam logic [15:0] VID = 16'h0f0e; // Arbitrary value
	localparam logic [15:0] PID = 16'h0d0c; // Arbitrary value
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic str_req_i = 1'b0;
	logic [1:0] str_sel_i = 2'h0;
	logic [3:0] str_idx_i = 4'h0;
	logic suspend_i = 1'b0;
	logic otp_req_i, otp_we_i, otp_ack_o, strings_from_otp_o, low_power_o, str_ack_o;
	logic core_clk_en_o, bus_voltage_sense_enable_o, self_powered_o, remote_wakeup_o;
	logic config_done_o;
	logic [8:0] otp_addr_i;
	logic [7:0] otp_wdata_i, otp_rdata_o, str_data_o, max_power_o, q;
	logic [15:0] vendor_id_o, product_id_o;
	char_format_s char_format_o;
	int err_count = 0;
	int n_tests = 0;
	logic [8:0] pa [15] = '{9'h000, 9'h003, 9'h004, 9'h005, 9'h006, 9'h007, 9'h008,
		9'h009, 9'h00a, 9'h00b, 9'h00c, 9'h00d, 9'h00e, 9'h00f, 9'h010};
	logic [7:0] pd [15] = '{8'h02, 8'h0a, 8'h07, 8'h80, 8'h25, 8'h00, 8'h00,
		8'h01, 8'h02, 8'h07, 8'hcd, 8'hab, 8'h34, 8'h12, 8'h40};
	initial
	begin
		forever #50 core_clk_i = ~core_clk_i;
	end
	otp_host_model host (.core_clk_i, .otp_ack_i(otp_ack_o), .otp_rdata_i(otp_rdata_o),
		.otp_req_o(otp_req_i), .otp_we_o(otp_we_i), .otp_addr_o(otp_addr_i),
		.otp_wdata_o(otp_wdata_i));
	otp_usb_config_override #(.BUILTIN_VENDOR_ID(VID), .BUILTIN_PRODUCT_ID(PID)) uut (
		.core_clk_i, .rst_n_i, .otp_req_i, .otp_we_i, .otp_addr_i, .otp_wdata_i,
		.otp_rdata_o, .otp_ack_o, .str_req_i, .str_sel_i, .str_idx_i, .str_data_o,
		.str_ack_o, .strings_from_otp_o, .suspend_i, .low_power_o, .core_clk_en_o,
		.bus_voltage_sense_enable_o, .vendor_id_o, .product_id_o, .self_powered_o,
		.remote_wakeup_o, .max_power_o, .char_format_o, .config_done_o);
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("compares %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic do_reset;
		int n;
		n = 0;
		@(negedge core_clk_i);
		rst_n_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		while (config_done_o !== 1'b1 && n < 80)
		begin
			@(negedge core_clk_i);
			n++;
		end
		check(config_done_o, 1'b1);
	endtask
	task automatic count_en(input int exp);
		int n;
		n = 0;
		repeat (32)
		begin
			@(posedge core_clk_i);
			#1;
			if (core_clk_en_o === 1'b1)
				n++;
		end
		check(n, exp);
	endtask
	task automatic lp_check(input logic s, input logic exp);
		@(negedge core_clk_i);
		suspend_i = s;
		@(negedge core_clk_i);
		check(low_power_o, exp);
	endtask
	task automatic t_defaults;
		do_reset();
		check(vendor_id_o, VID);
		check(product_id_o, PID);
		check(strings_from_otp_o, 1'b0);
		check(bus_voltage_sense_enable_o, 1'b0);
		check(char_format_o, {DEF_BAUD, DEF_STOP, DEF_PARITY, DEF_DATA_BITS});
		lp_check(1'b1, 1'b0);
		lp_check(1'b0, 1'b1);
		count_en(32);
		host.access(1'b0, ADDR_USER, 8'h00, q);
		check(q, 8'h00);
	endtask
	task automatic t_override;
		foreach (pa[i]) host.access(1'b1, pa[i], pd[i], q);
		host.access(1'b1, ADDR_MAX_PWR, 8'h64, q);
		host.access(1'b1, ADDR_STR_MFR, 8'h41, q);
		host.access(1'b0, ADDR_VEND_HI, 8'h00, q);
		check(q, 8'hab);
		check(vendor_id_o, VID);
		do_reset();
		check(vendor_id_o, 16'habcd);
		check(product_id_o, 16'h1234);
		check({self_powered_o, remote_wakeup_o, max_power_o}, 10'h264);
		check(strings_from_otp_o, 1'b1);
		check(bus_voltage_sense_enable_o, 1'b1);
		check(char_format_o, {32'h00002580, 8'h01, 8'h02, 8'h07});
		lp_check(1'b1, 1'b1);
		lp_check(1'b0, 1'b0);
		count_en(8);
		@(negedge core_clk_i);
		str_req_i = 1'b1;
		str_sel_i = STR_SEL_MFR;
		repeat (2) @(posedge core_clk_i);
		#1;
		check({str_ack_o, str_data_o}, 9'h141);
		@(negedge core_clk_i);
		str_req_i = 1'b0;
		str_idx_i = 4'hf;
		host.access(1'b1, ADDR_CLK_SENSE, 8'h01, q);
		count_en(8);
		do_reset();
		count_en(4);
	endtask
	initial
	begin
		#300000;
		err_count++;
		end_sim();
	end
	initial
	begin
		t_defaults();
		t_override();
		end_sim();
	end
endmodule
